// File: emc_pkg.sv
// Shared constants and types for the embedded RAM clocking block.
// Assumes every user of it refers to names as emc_pkg::name.
package emc_pkg;

  // Array geometry
  localparam int DATA_W = 16;
  localparam int BYTE_W = 8;
  localparam int BE_W   = DATA_W / BYTE_W;
  localparam int ADDR_W = 8;
  localparam int DEPTH  = 256;

  // Register port geometry and map
  localparam int REG_AW = 8;
  localparam int REG_DW = 32;
  localparam logic [REG_AW-1:0] REG_CTRL = 8'h00;
  localparam logic [REG_AW-1:0] REG_STAT = 8'h04;

  // Control word: width and reset value (single clock, true dual port,
  // both output registers bypassed, old-data mixed-port behaviour)
  localparam int CTRL_W = 7;
  localparam logic [CTRL_W-1:0] CTRL_RST = 7'h4b;

  // Status word bit positions
  localparam int STAT_W       = 3;
  localparam int STAT_CFG_ERR = 0;
  localparam int STAT_MIXED   = 1;
  localparam int STAT_CLASH   = 2;

  // Clock modes
  typedef enum logic [1:0] {
    EMC_CLK_IND = 2'h0,
    EMC_CLK_IO  = 2'h1,
    EMC_CLK_RW  = 2'h2,
    EMC_CLK_ONE = 2'h3
  } emc_clk_e;

  // Memory modes; code 2'h3 is illegal
  typedef enum logic [1:0] {
    EMC_MEM_SP  = 2'h0,
    EMC_MEM_SDP = 2'h1,
    EMC_MEM_TDP = 2'h2
  } emc_mem_e;

  // Control word layout, low bit last
  typedef struct packed {
    logic     old_data;
    logic     oreg_b;
    logic     oreg_a;
    emc_mem_e mem;
    emc_clk_e clk;
  } emc_cfg_s;

endpackage

// File: emc_port_out.sv
// Read stage of one RAM port: raw read latch plus optional output register.
// Assumes the fire strobes already carry all clock and enable gating.
`timescale 1ns/100ps
module emc_port_out
(
  input  wire logic                      clk_sys,
  input  wire logic                      rst_n,
  input  wire logic                      rd_fire,
  input  wire logic [emc_pkg::DATA_W-1:0] rd_val,
  input  wire logic                      out_fire,
  input  wire logic                      bypass,
  output logic      [emc_pkg::DATA_W-1:0] raw,
  output logic      [emc_pkg::DATA_W-1:0] dout
);

  logic [emc_pkg::DATA_W-1:0] next_dout;

  // Bypass loads the read value together with the raw latch, so the
  // port output still comes from a flop yet shows the read at once
  assign next_dout = bypass ? (rd_fire ? rd_val : dout)
                            : (out_fire ? raw : dout);

  // Reset here stands for power-up only; outputs start cleared
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      raw  <= '0;
      dout <= '0;
    end
    else
    begin
      if (rd_fire)
        raw <= rd_val;
      dout <= next_dout;
    end
  end

endmodule

// File: emc_ram_clocking.sv
// Embedded two-port block RAM with selectable clock and memory modes.
// Assumes port clocks arrive as one-cycle edge strobes on clk_sys and
// that user logic keeps both ports from writing one word together.
//
// How it works
// R1 - Each clock mode only in its memory modes
// R2 - Independent mode: port A, port B own clocks
// R3 - Independent mode: one enable per port
// R4 - No asynchronous clear on block registers
// R5 - IO mode: input clock, separate output clock
// R6 - IO mode: separate input and output enables
// R7 - RW mode: write clock drives write registers
// R8 - RW mode: read clock drives read registers
// R9 - RW mode: separate write and read enables
// R10 - Single mode: one clock, one common enable
// R11 - Outputs power up as zeros
// R12 - Preloaded word appears on first read
// R13 - Same-port read of written address shows new data
// R14 - Masked bytes may be unknown, unmasked new
// R15 - Mixed-port behaviour selectable: old or don't care
// R16 - Old data returns word before the write
// R17 - Don't care may return any value
// R18 - User ignores mixed reads across different clocks
// R19 - User avoids simultaneous writes to one word
// R20 - Read enable low holds the output word
// R21 - Output register adds one output-clock edge
//
// Our own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/100ps
module emc_ram_clocking
#(
  parameter logic [emc_pkg::DATA_W-1:0] INIT_SEED = 16'h0000
)
(
  input  wire logic                       clk_sys,
  input  wire logic                       rst_n,
  input  wire logic                       ce,
  input  wire logic [emc_pkg::REG_AW-1:0] reg_addr,
  input  wire logic [emc_pkg::REG_DW-1:0] reg_wdata,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  output logic      [emc_pkg::REG_DW-1:0] reg_rdata,
  input  wire logic                       a_clk_in,
  input  wire logic                       a_clk_out,
  input  wire logic                       a_ce_in,
  input  wire logic                       a_ce_out,
  input  wire logic [emc_pkg::ADDR_W-1:0] a_addr,
  input  wire logic [emc_pkg::DATA_W-1:0] a_din,
  input  wire logic [emc_pkg::BE_W-1:0]   a_be,
  input  wire logic                       a_we,
  input  wire logic                       a_rden,
  output logic      [emc_pkg::DATA_W-1:0] a_dout,
  input  wire logic                       b_clk_in,
  input  wire logic                       b_clk_out,
  input  wire logic                       b_ce_in,
  input  wire logic                       b_ce_out,
  input  wire logic [emc_pkg::ADDR_W-1:0] b_addr,
  input  wire logic [emc_pkg::DATA_W-1:0] b_din,
  input  wire logic [emc_pkg::BE_W-1:0]   b_be,
  input  wire logic                       b_we,
  input  wire logic                       b_rden,
  output logic      [emc_pkg::DATA_W-1:0] b_dout
);

  localparam int DW = emc_pkg::DATA_W;
  localparam int BW = emc_pkg::BYTE_W;

  emc_pkg::emc_cfg_s          cfg;
  logic [emc_pkg::STAT_W-1:0] stat;
  logic [emc_pkg::STAT_W-1:0] next_stat;
  logic [emc_pkg::REG_DW-1:0] next_rdata;
  logic [DW-1:0]              mem [emc_pkg::DEPTH];
  logic                       a_in;
  logic                       a_out;
  logic                       b_in;
  logic                       b_out;
  logic [DW-1:0]              a_raw;
  logic [DW-1:0]              b_raw;

  // Register decode
  wire ctrl_sel = reg_addr == emc_pkg::REG_CTRL;
  wire stat_sel = reg_addr == emc_pkg::REG_STAT;
  wire reg_we   = ce & reg_wr;

  // Mode legality; an illegal pairing stops every port edge
  wire mem_bad = cfg.mem == emc_pkg::emc_mem_e'(2'h3);
  wire cfg_err = mem_bad
    | (cfg.clk == emc_pkg::EMC_CLK_IND & cfg.mem != emc_pkg::EMC_MEM_TDP)
    | (cfg.clk == emc_pkg::EMC_CLK_RW & cfg.mem != emc_pkg::EMC_MEM_SDP);
  wire run = ce & ~cfg_err; // [R1]

  // Gated edges of each documented clock
  wire a_tick_in  = run & a_clk_in & a_ce_in;
  wire a_tick_out = run & a_clk_out & a_ce_out;
  wire b_tick_in  = run & b_clk_in & b_ce_in;
  wire b_tick_out = run & b_clk_out & b_ce_out;

  // Route gated edges to register groups per clock mode
  always_comb
  begin
    a_in  = 1'b0;
    a_out = 1'b0;
    b_in  = 1'b0;
    b_out = 1'b0;
    unique case (cfg.clk)
      emc_pkg::EMC_CLK_IND:
      begin
        a_in  = a_tick_in;  // [R2] [R3]
        a_out = a_tick_in;
        b_in  = b_tick_in;
        b_out = b_tick_in;
      end
      emc_pkg::EMC_CLK_IO:
      begin
        a_in  = a_tick_in;  // [R5] [R6]
        a_out = a_tick_out;
        b_in  = b_tick_in;
        b_out = b_tick_out;
      end
      emc_pkg::EMC_CLK_RW:
      begin
        a_in  = a_tick_in;  // Write side [R7] [R9]
        b_in  = b_tick_in;  // Read side [R8]
        b_out = b_tick_in;
      end
      emc_pkg::EMC_CLK_ONE:
      begin
        a_in  = a_tick_in;  // Port A clock and enable serve all [R10]
        a_out = a_tick_in;
        b_in  = a_tick_in;
        b_out = a_tick_in;
      end
    endcase
  end

  // Port roles per memory mode: single port uses A only, simple dual
  // port writes on A and reads on B
  wire is_sp  = cfg.mem == emc_pkg::EMC_MEM_SP;
  wire is_sdp = cfg.mem == emc_pkg::EMC_MEM_SDP;
  wire is_tdp = cfg.mem == emc_pkg::EMC_MEM_TDP;
  wire a_wr   = a_in & a_we;
  wire b_wr   = b_in & b_we & is_tdp;
  wire a_rd   = a_in & a_rden & ~is_sdp; // [R20]
  wire b_rd   = b_in & b_rden & ~is_sp;  // [R20]

  // Stored words and byte-merged write words
  wire [DW-1:0] a_mem = mem[a_addr];
  wire [DW-1:0] b_mem = mem[b_addr];
  logic [DW-1:0] a_word;
  logic [DW-1:0] b_word;

  // Masked bytes keep the stored byte, which is one legal unknown
  for (genvar g = 0; g < emc_pkg::BE_W; g++)
  begin : g_byte
    assign a_word[g*BW +: BW] = a_be[g] ? a_din[g*BW +: BW]
                                        : a_mem[g*BW +: BW]; // [R14]
    assign b_word[g*BW +: BW] = b_be[g] ? b_din[g*BW +: BW]
                                        : b_mem[g*BW +: BW]; // [R14]
  end

  // Read values: same-port writes flow through, mixed-port reads on a
  // common clock take old or forwarded data as selected
  wire same_addr = a_addr == b_addr;
  wire one_clk   = cfg.clk == emc_pkg::EMC_CLK_ONE;
  wire fwd       = one_clk & ~cfg.old_data & same_addr; // [R15] [R17]
  wire [DW-1:0] a_rd_val = a_wr ? a_word            // [R13]
                         : (b_wr & fwd) ? b_word
                         : a_mem;                   // [R16]
  wire [DW-1:0] b_rd_val = b_wr ? b_word            // [R13]
                         : (a_wr & fwd) ? a_word
                         : b_mem;                   // [R16]

  // Events logged for software
  wire mixed = same_addr & ((a_rd & b_wr) | (b_rd & a_wr));
  wire clash = same_addr & a_wr & b_wr;

  // Preload: the array holds INIT_SEED xor address from configuration
  initial
  begin
    for (int i = 0; i < emc_pkg::DEPTH; i++)
      mem[i] = INIT_SEED ^ DW'(i); // [R12]
  end

  // Array writes; port A lands last so a clash keeps A's word. Plain
  // always, as the preload block above also writes the array
  always @(posedge clk_sys)
  begin
    if (b_wr)
      mem[b_addr] <= b_word; // [R4]
    if (a_wr)
      mem[a_addr] <= a_word; // [R19]
  end

  // Read stages; outputs start at zero even over a preloaded array
  emc_port_out u_out_a
  (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .rd_fire  (a_rd),
    .rd_val   (a_rd_val),
    .out_fire (a_out),
    .bypass   (~cfg.oreg_a),
    .raw      (a_raw),
    .dout     (a_dout)
  ); // [R11] [R21]

  emc_port_out u_out_b
  (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .rd_fire  (b_rd),
    .rd_val   (b_rd_val),
    .out_fire (b_out),
    .bypass   (~cfg.oreg_b),
    .raw      (b_raw),
    .dout     (b_dout)
  ); // [R11] [R21]

  // Status: live config error, sticky events cleared by writing one;
  // an event in the clearing cycle survives
  wire [emc_pkg::STAT_W-1:0] stat_clr =
    (reg_we & stat_sel) ? reg_wdata[emc_pkg::STAT_W-1:0] : '0;
  assign next_stat[emc_pkg::STAT_CFG_ERR] = cfg_err;
  assign next_stat[emc_pkg::STAT_MIXED] = mixed
    | (stat[emc_pkg::STAT_MIXED] & ~stat_clr[emc_pkg::STAT_MIXED]);
  assign next_stat[emc_pkg::STAT_CLASH] = clash
    | (stat[emc_pkg::STAT_CLASH] & ~stat_clr[emc_pkg::STAT_CLASH]);

  // Read data stands for one cycle only, zero otherwise
  assign next_rdata = ~reg_rd ? '0
    : ctrl_sel ? {{(emc_pkg::REG_DW-emc_pkg::CTRL_W){1'b0}}, cfg}
    : stat_sel ? {{(emc_pkg::REG_DW-emc_pkg::STAT_W){1'b0}}, stat}
    : '0;

  // Control register
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      cfg <= emc_pkg::CTRL_RST;
    else if (reg_we & ctrl_sel)
      cfg <= emc_pkg::emc_cfg_s'(reg_wdata[emc_pkg::CTRL_W-1:0]);
  end

  // Status and read data; both freeze with the global enable
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stat      <= '0;
      reg_rdata <= '0;
    end
    else if (ce)
    begin
      stat      <= next_stat;
      reg_rdata <= next_rdata;
    end
  end

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  cfg_legal_a: assert property (cfg_err |-> !(a_in|a_out|b_in|b_out)) // [R1]
    else $error("port edge in illegal mode");

  ind_split_a: assert property (cfg.clk == emc_pkg::EMC_CLK_IND && !cfg_err
    && !cfg.oreg_b && b_tick_in && b_rden && !a_tick_in
    |=> b_dout == $past(b_rd_val)) // [R2]
    else $error("port B read not on its own clock");

  ind_ce_a: assert property (cfg.clk == emc_pkg::EMC_CLK_IND && !a_ce_in
    |=> $stable(a_dout)) // [R3]
    else $error("port A moved with its enable low");

  freeze_a: assert property (!ce |=> $stable(a_dout) && $stable(b_dout)
    && $stable(cfg)) // [R4]
    else $error("state changed while frozen");

  io_outreg_a: assert property (cfg.clk == emc_pkg::EMC_CLK_IO
    && cfg.oreg_a && !a_tick_out |=> $stable(a_dout)) // [R5]
    else $error("output register moved without output edge");

  io_incap_a: assert property (cfg.clk == emc_pkg::EMC_CLK_IO
    && !a_ce_in |=> $stable(a_raw)) // [R6]
    else $error("input stage moved with input enable low");

  rw_read_a: assert property (cfg.clk == emc_pkg::EMC_CLK_RW
    && !b_tick_in |=> $stable(b_dout) && $stable(b_raw)) // [R8]
    else $error("read side moved without read clock");

  one_clk_a: assert property (one_clk && !a_tick_in
    |=> $stable(a_dout) && $stable(b_dout)) // [R10]
    else $error("single clock mode moved without edge");

  pwr_zero_a: assert property ($rose(rst_n) |-> a_dout == '0
    && b_dout == '0) // [R11]
    else $error("output not zero after power-up");

  same_port_a: assert property (a_wr && a_rd && !cfg.oreg_a
    |=> a_dout == $past(a_word)) // [R13]
    else $error("written word not flowing through");

  old_data_a: assert property (one_clk && cfg.old_data && b_rd && a_wr
    && !b_wr && same_addr && !cfg.oreg_b |=> b_dout == $past(b_mem)) // [R16]
    else $error("mixed read did not return old data");

  hold_rd_a: assert property (is_sdp && !cfg.oreg_b && !b_rd
    |=> $stable(b_dout)) // [R20]
    else $error("output moved with read enable low");

  out_lat_a: assert property (cfg.oreg_a && a_out && $stable(cfg)
    |=> a_dout == $past(a_raw)) // [R21]
    else $error("output register latency wrong");

  same_port_c: cover property (a_wr && a_rd && same_addr);
  mixed_c:     cover property (mixed ##1 stat[emc_pkg::STAT_MIXED]);
  io_mode_c:   cover property (cfg.clk == emc_pkg::EMC_CLK_IO
    && cfg.oreg_a && a_rd ##[1:8] a_out);
  rw_mode_c:   cover property (cfg.clk == emc_pkg::EMC_CLK_RW
    && a_wr ##1 b_rd);

endmodule

// File: emc_user.sv
// Fabric-side model that drives both RAM ports with edge strobes.
// Assumes clk_sys is the only clock; port clocks are one-cycle pulses.
`timescale 1ns/100ps
module emc_user
(
  input  wire logic                       clk_sys,
  output logic                            a_clk_in,
  output logic                            a_clk_out,
  output logic                            a_ce_in,
  output logic                            a_ce_out,
  output logic      [emc_pkg::ADDR_W-1:0] a_addr,
  output logic      [emc_pkg::DATA_W-1:0] a_din,
  output logic      [emc_pkg::BE_W-1:0]   a_be,
  output logic                            a_we,
  output logic                            a_rden,
  output logic                            b_clk_in,
  output logic                            b_ce_in,
  output logic      [emc_pkg::ADDR_W-1:0] b_addr,
  output logic      [emc_pkg::DATA_W-1:0] b_din,
  output logic                            b_we,
  output logic      [emc_pkg::BE_W-1:0]   b_be,
  output logic                            b_rden
);
  // Quiet levels at time zero
  initial
  begin
    {a_clk_in, a_clk_out, a_ce_in, a_ce_out, a_we, a_rden} = '0;
    {b_clk_in, b_ce_in, b_rden, a_addr, a_din, a_be} = '0;
    {b_addr, b_din, b_we} = '0;
    b_be = 2'h3;
  end

  // One input edge on both ports; B writes only through bwr, when A
  // has no edge, so both ports never write one word together
  task automatic cyc(input logic awe, ace, input logic [7:0] aad,
                     input logic [15:0] adi, input logic [1:0] abe,
                     input logic ard, bce, input logic [7:0] bad,
                     input logic brd);
    @(posedge clk_sys);
    a_clk_in <= 1'b1;
    b_clk_in <= 1'b1;
    a_ce_in  <= ace;
    b_ce_in  <= bce;
    a_we     <= awe;
    a_addr   <= aad;
    a_din    <= adi;
    a_be     <= abe;
    a_rden   <= ard;
    b_addr   <= bad;
    b_din    <= ~adi;
    b_rden   <= brd;
    @(posedge clk_sys);
    // Released lines show the inverse, so a stale value never passes
    a_clk_in <= 1'b0;
    b_clk_in <= 1'b0;
    a_we     <= 1'b0;
    a_rden   <= 1'b0;
    b_rden   <= 1'b0;
    a_addr   <= ~aad;
    a_din    <= ~adi;
    b_addr   <= ~bad;
    @(negedge clk_sys);
  endtask

  // One write edge on port B alone, reading the same word back
  task automatic bwr(input logic [7:0] bad, input logic [15:0] bdi,
                     input logic [1:0] bbe);
    @(posedge clk_sys);
    b_clk_in <= 1'b1;
    b_ce_in  <= 1'b1;
    b_we     <= 1'b1;
    b_rden   <= 1'b1;
    b_addr   <= bad;
    b_din    <= bdi;
    b_be     <= bbe;
    @(posedge clk_sys);
    b_clk_in <= 1'b0;
    b_we     <= 1'b0;
    b_rden   <= 1'b0;
    b_addr   <= ~bad;
    b_din    <= ~bdi;
    @(negedge clk_sys);
  endtask

  // One output-clock edge on port A with the given output enable
  task automatic oedge(input logic oce);
    @(posedge clk_sys);
    a_clk_out <= 1'b1;
    a_ce_out  <= oce;
    @(posedge clk_sys);
    a_clk_out <= 1'b0;
    a_ce_out  <= 1'b0;
    @(negedge clk_sys);
  endtask
endmodule

// File: emc_ram_clocking_tb.sv
// Self-checking bench for the embedded RAM clocking block.
// Assumes emc_user drives the RAM ports; the bench owns the reg port.
`timescale 1ns/100ps
module emc_ram_clocking_tb;
  localparam logic [15:0] SEED = 16'h5a00;
  logic        clk_sys   = 1'b0;
  logic        rst_n     = 1'b0;
  logic        ce        = 1'b1;
  logic [7:0]  reg_addr  = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic [31:0] reg_rdata;
  logic        a_clk_in, a_clk_out, a_ce_in, a_ce_out, a_we, a_rden;
  logic        b_clk_in, b_ce_in, b_rden, b_we;
  logic [7:0]  a_addr, b_addr;
  logic [15:0] a_din, b_din, a_dout, b_dout;
  logic [1:0]  a_be, b_be;
  int          err_count       = 0;
  int          samples_checked = 0;

  // Half period of the 40 MHz clock
  always #12.5 clk_sys = ~clk_sys;

  emc_user i_emc_user (.clk_sys(clk_sys), .a_clk_in(a_clk_in),
    .a_clk_out(a_clk_out), .a_ce_in(a_ce_in), .a_ce_out(a_ce_out),
    .a_addr(a_addr), .a_din(a_din), .a_be(a_be), .a_we(a_we),
    .a_rden(a_rden), .b_clk_in(b_clk_in), .b_ce_in(b_ce_in),
    .b_addr(b_addr), .b_din(b_din), .b_rden(b_rden), .b_we(b_we),
    .b_be(b_be));

  // B has no output clock in these scenarios, so that pair stays fixed
  emc_ram_clocking #(.INIT_SEED(SEED)) i_emc_ram_clocking (
    .clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .a_clk_in(a_clk_in), .a_clk_out(a_clk_out),
    .a_ce_in(a_ce_in), .a_ce_out(a_ce_out), .a_addr(a_addr),
    .a_din(a_din), .a_be(a_be), .a_we(a_we), .a_rden(a_rden),
    .a_dout(a_dout), .b_clk_in(b_clk_in), .b_clk_out(1'b0),
    .b_ce_in(b_ce_in), .b_ce_out(1'b0), .b_addr(b_addr), .b_din(b_din),
    .b_be(b_be), .b_we(b_we), .b_rden(b_rden), .b_dout(b_dout));

  // Preloaded word at an address
  function automatic logic [15:0] pre(input logic [7:0] i);
    return SEED ^ {8'h00, i};
  endfunction

  task automatic chk(input string nm, input logic [15:0] e, g);
    samples_checked++;
    if (g !== e)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic reg_write(input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr  <= ad;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic reg_read(input logic [7:0] ad, input logic [31:0] e);
    @(posedge clk_sys);
    reg_addr <= ad;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    @(negedge clk_sys);
    samples_checked++;
    if (reg_rdata !== e)
    begin
      err_count++;
      $display("[ERR] reg_rdata expected %h seen %h", e, reg_rdata);
    end
  endtask

  task automatic t_reset();
    @(negedge clk_sys);
    chk("a_dout", 16'h0, a_dout);
    chk("b_dout", 16'h0, b_dout);
    reg_read(emc_pkg::REG_CTRL, 32'h4b);
    reg_read(emc_pkg::REG_STAT, 32'h0);
    reg_read(8'h10, 32'h0);
  endtask

  // Single clock, true dual port, both outputs bypassed
  task automatic t_single();
    i_emc_user.cyc(1'b0, 1'b1, 8'h03, 16'h0, 2'h3, 1'b1, 1'b1, 8'h0, 1'b0);
    chk("a_dout", pre(8'h03), a_dout);
    i_emc_user.cyc(1'b0, 1'b0, 8'h04, 16'h0, 2'h3, 1'b1, 1'b1, 8'h0, 1'b0);
    chk("a_dout", pre(8'h03), a_dout);
    i_emc_user.cyc(1'b0, 1'b1, 8'h05, 16'h0, 2'h3, 1'b0, 1'b1, 8'h0, 1'b0);
    chk("a_dout", pre(8'h03), a_dout);
    i_emc_user.cyc(1'b1, 1'b1, 8'h09, 16'h1234, 2'h1, 1'b1, 1'b1, 8'h0, 1'b0);
    chk("a_dout", (pre(8'h09) & 16'hff00) | 16'h0034, a_dout);
    i_emc_user.cyc(1'b0, 1'b1, 8'h09, 16'h0, 2'h3, 1'b1, 1'b1, 8'h0, 1'b0);
    chk("a_dout", (pre(8'h09) & 16'hff00) | 16'h0034, a_dout);
  endtask

  // A writes while B reads the same word on the common clock
  task automatic t_mixed();
    i_emc_user.cyc(1'b1, 1'b1, 8'h07, 16'hbeef, 2'h3, 1'b0, 1'b1, 8'h07, 1'b1);
    chk("b_dout", pre(8'h07), b_dout);
    reg_read(emc_pkg::REG_STAT, 32'h2);
    reg_write(emc_pkg::REG_STAT, 32'h2);
    reg_write(emc_pkg::REG_CTRL, 32'h0b);
    i_emc_user.cyc(1'b1, 1'b1, 8'h08, 16'hcafe, 2'h3, 1'b0, 1'b1, 8'h08, 1'b1);
    chk("b_dout", 16'hcafe, b_dout);
    reg_write(emc_pkg::REG_STAT, 32'h2);
  endtask

  // Output register on A, then input/output clocking of A
  task automatic t_oreg_io();
    reg_write(emc_pkg::REG_CTRL, 32'h5b);
    i_emc_user.cyc(1'b0, 1'b1, 8'h09, 16'h0, 2'h3, 1'b1, 1'b1, 8'h0, 1'b0);
    i_emc_user.cyc(1'b0, 1'b1, 8'h03, 16'h0, 2'h3, 1'b1, 1'b1, 8'h0, 1'b0);
    chk("a_dout", (pre(8'h09) & 16'hff00) | 16'h0034, a_dout);
    i_emc_user.cyc(1'b0, 1'b1, 8'h04, 16'h0, 2'h3, 1'b1, 1'b1, 8'h0, 1'b0);
    chk("a_dout", pre(8'h03), a_dout);
    reg_write(emc_pkg::REG_CTRL, 32'h59);
    i_emc_user.cyc(1'b0, 1'b1, 8'h09, 16'h0, 2'h3, 1'b1, 1'b1, 8'h0, 1'b0);
    chk("a_dout", pre(8'h03), a_dout);
    i_emc_user.oedge(1'b0);
    chk("a_dout", pre(8'h03), a_dout);
    i_emc_user.oedge(1'b1);
    chk("a_dout", (pre(8'h09) & 16'hff00) | 16'h0034, a_dout);
    i_emc_user.cyc(1'b0, 1'b0, 8'h03, 16'h0, 2'h3, 1'b1, 1'b1, 8'h0, 1'b0);
    i_emc_user.oedge(1'b1);
    chk("a_dout", (pre(8'h09) & 16'hff00) | 16'h0034, a_dout);
  endtask

  // Global enable low freezes everything, then B writes on its own clock
  task automatic t_freeze();
    @(posedge clk_sys);
    ce <= 1'b0;
    i_emc_user.cyc(1'b1, 1'b1, 8'h0b, 16'h0, 2'h3, 1'b1, 1'b1, 8'h03, 1'b1);
    chk("a_dout", pre(8'h03), a_dout);
    chk("b_dout", 16'h7777, b_dout);
    reg_write(emc_pkg::REG_CTRL, 32'h4b);
    ce <= 1'b1;
    reg_read(emc_pkg::REG_CTRL, 32'h48);
    i_emc_user.cyc(1'b0, 1'b1, 8'h0b, 16'h0, 2'h3, 1'b1, 1'b0, 8'h0, 1'b0);
    chk("a_dout", 16'h7777, a_dout);
    i_emc_user.bwr(8'h0d, 16'habcd, 2'h2);
    chk("b_dout", (pre(8'h0d) & 16'h00ff) | 16'hab00, b_dout);
    i_emc_user.cyc(1'b0, 1'b1, 8'h0d, 16'h0, 2'h3, 1'b1, 1'b0, 8'h0, 1'b0);
    chk("a_dout", (pre(8'h0d) & 16'h00ff) | 16'hab00, a_dout);
  endtask

  // Illegal pairings refuse, then read/write and independent clocking
  task automatic t_modes();
    logic [31:0] bad [3] = '{32'h40, 32'h4a, 32'h4e};
    foreach (bad[i])
    begin
      reg_write(emc_pkg::REG_CTRL, bad[i]);
      repeat (3) @(posedge clk_sys);
      reg_read(emc_pkg::REG_STAT, 32'h1);
    end
    i_emc_user.cyc(1'b0, 1'b1, 8'h03, 16'h0, 2'h3, 1'b1, 1'b1, 8'h0, 1'b0);
    chk("a_dout", (pre(8'h09) & 16'hff00) | 16'h0034, a_dout);
    reg_write(emc_pkg::REG_CTRL, 32'h46);
    repeat (3) @(posedge clk_sys);
    reg_read(emc_pkg::REG_STAT, 32'h0);
    // Reader never looks at the word being written
    i_emc_user.cyc(1'b1, 1'b1, 8'h0b, 16'h7777, 2'h3, 1'b0, 1'b1, 8'h03, 1'b1);
    chk("b_dout", pre(8'h03), b_dout);
    i_emc_user.cyc(1'b1, 1'b0, 8'h0c, 16'h1111, 2'h3, 1'b0, 1'b1, 8'h0b, 1'b1);
    chk("b_dout", 16'h7777, b_dout);
    i_emc_user.cyc(1'b0, 1'b1, 8'h0, 16'h0, 2'h3, 1'b0, 1'b0, 8'h09, 1'b1);
    chk("b_dout", 16'h7777, b_dout);
    i_emc_user.cyc(1'b0, 1'b1, 8'h0, 16'h0, 2'h3, 1'b0, 1'b1, 8'h0c, 1'b1);
    chk("b_dout", pre(8'h0c), b_dout);
    reg_write(emc_pkg::REG_CTRL, 32'h48);
    i_emc_user.cyc(1'b0, 1'b1, 8'h03, 16'h0, 2'h3, 1'b1, 1'b0, 8'h0b, 1'b1);
    chk("a_dout", pre(8'h03), a_dout);
    chk("b_dout", pre(8'h0c), b_dout);
    i_emc_user.cyc(1'b0, 1'b0, 8'h0b, 16'h0, 2'h3, 1'b1, 1'b1, 8'h0b, 1'b1);
    chk("a_dout", pre(8'h03), a_dout);
    chk("b_dout", 16'h7777, b_dout);
  endtask

  task automatic end_sim();
    $display("Checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Main sequence after a 12-cycle reset
  initial
  begin
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_reset();
    t_single();
    t_mixed();
    t_oreg_io();
    t_modes();
    t_freeze();
    end_sim();
  end

  // Watchdog well beyond the roughly 120 cycles the tests need
  initial
  begin
    #50000;
    err_count++;
    end_sim();
  end
endmodule
